// ---- logic/spr_defines.vh ----
// Purpose: constants for the serial port baud generator and synchronous receiver
// Assumes: 50 MHz system clock, registers on a plain strobe port
// Notes:   offsets are byte-wide register indices
`ifndef SPR_DEFINES_VH
`define SPR_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SPR_ADDR_W          3
`define SPR_OFF_DIV_LO      3'h0
`define SPR_OFF_DIV_HI      3'h1
`define SPR_OFF_BAUD_CTRL   3'h2
`define SPR_OFF_TX_CTRL     3'h3
`define SPR_OFF_RX_CTRL     3'h4
`define SPR_OFF_RX_DATA     3'h5
// ----------------------------------------
// field positions
// ----------------------------------------
`define SPR_BC_WIDE         3
`define SPR_BC_IDLE         6
`define SPR_TC_HSPEED       2
`define SPR_TC_SYNC         4
`define SPR_TC_MASTER       7
`define SPR_RC_NINTH_D      0
`define SPR_RC_OVERRUN      1
`define SPR_RC_PENDING      3
`define SPR_RC_CONT         4
`define SPR_RC_SINGLE       5
`define SPR_RC_NINTH_EN     6
`define SPR_RC_PORT_EN      7
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SPR_RST_BYTE        8'h00
`define SPR_ASYNC_LOW_MULT  7'h40
`define SPR_FIFO_DEPTH      2
`endif

// ---- logic/spr_sync2.v ----
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: i_async comes from outside the clock domain
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module spr_sync2 (
   input  wire i_clock,
   input  wire i_rst_b,
   input  wire i_async,
   output reg  o_sync
);
   reg meta_r;
   // ----------------------------------------
   // two stages
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         meta_r <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ---- logic/spr_baud_generator.v ----
// Purpose: free-running baud timer, 8 or 16 bits wide
// Assumes: divisor and mode bits come from the register file
// Notes:   o_tick is a one-cycle enable at each timer overflow
`timescale 1ns/1ps
`default_nettype none
module spr_baud_generator #(
   parameter DIV_W = 16
) (
   input  wire             i_clock,
   input  wire             i_rst_b,
   input  wire             i_clear,
   input  wire [DIV_W-1:0] i_divisor,
   input  wire             i_wide,
   input  wire             i_sync,
   input  wire             i_hspeed,
   output reg              o_tick
);
   reg  [DIV_W-1:0] count_r;
   reg  [5:0]       pre_r;
   wire [DIV_W-1:0] top;
   wire [5:0]       pre_top;
   wire             at_top;
   // 8-bit width by default, 16 bits when wide is set
   assign top = i_wide ? i_divisor : {{(DIV_W-8){1'b0}}, i_divisor[7:0]};
   // sync ignores high speed: fixed /4; async low speed 8-bit: /64; else /16 or /4
   assign pre_top = i_sync ? 6'h03 :
                    (!i_hspeed && !i_wide) ? 6'h3f :
                    (i_hspeed && i_wide) ? 6'h03 : 6'h0f;
   assign at_top = (count_r == top);
   // ----------------------------------------
   // prescaler and timer
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (!i_rst_b || i_clear) begin
         count_r <= {DIV_W{1'b0}};
         pre_r   <= 6'h00;
         o_tick  <= 1'b0;
      end else begin
         o_tick <= 1'b0;
         if (pre_r == pre_top) begin
            pre_r <= 6'h00;
            if (at_top) begin
               count_r <= {DIV_W{1'b0}};
               o_tick  <= 1'b1;
            end else begin
               count_r <= count_r + {{(DIV_W-1){1'b0}}, 1'b1};
            end
         end else begin
            pre_r <= pre_r + 6'h01;
         end
      end
   end
endmodule
`default_nettype wire

// ---- logic/spr_serial_port.v ----
// Purpose: serial port baud generator and synchronous receive path
// Assumes: one clock; registers on a plain strobe port, read data one cycle later
// Notes:   clearing the port enable resets receive state and the FIFO
`include "spr_defines.vh"
`timescale 1ns/1ps
`default_nettype none
// Function
// - baud timer 8-bit, 16-bit with wide select
// - divisor registers set baud timer period
// - async multiplier uses both bits; sync ignores speed
// - divisor write clears baud timer immediately
// - async 8-bit low speed: Fosc/(64(n+1))
// - master receive disables data pin driver
// - single or continuous enable starts reception
// - single: one character of clocks, self-clears
// - continuous: clocks until cleared, partial dropped
// - both set: single clears after first
// - sample data on trailing clock edge
// - full character sets pending, enters FIFO
// - pending stays while FIFO holds characters
// - slave takes clock pin, disables driver
// - bits change leading edge, one per clock
// - third character sets overrun, keeps data
// - overrun clears by read or continuous/enable
// - nine-bit mode, ninth bit readable
module spr_serial_port (
   input  wire                     i_clock,
   input  wire                     i_rst_b,
   input  wire [`SPR_ADDR_W-1:0]   i_addr,
   input  wire [7:0]               i_wdata,
   input  wire                     i_wr,
   input  wire                     i_rd,
   output reg  [7:0]               o_rdata,
   input  wire                     i_data_pin,
   output wire                     o_data_pin,
   output wire                     o_data_pin_oe,
   input  wire                     i_clock_pin,
   output wire                     o_clock_pin,
   output wire                     o_clock_pin_oe
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg  [7:0]  div_lo_r;
   reg  [7:0]  div_hi_r;
   reg         wide_r;
   reg         hspeed_r;
   reg         sync_r;
   reg         master_r;
   reg         port_en_r;
   reg         single_r;
   reg         cont_r;
   reg         ninth_en_r;
   reg         overrun_r;
   reg         ovr_single_r;
   reg  [8:0]  fifo_r [0:`SPR_FIFO_DEPTH-1];
   reg  [1:0]  count_r;
   reg  [8:0]  shift_r;
   reg  [3:0]  bits_r;
   reg         sck_r;
   reg         sck_prev_r;
   reg         data_d_r;
   wire        tick;
   wire        data_s;
   wire        clk_s;
   wire        wr_div;
   wire        rd_data;
   wire        wr_rx;
   wire        active;
   wire        trail;
   wire        done;
   wire [3:0]  char_bits;
   wire        port_rst;
   wire        cont_nxt;
   wire        port_en_nxt;
   wire        bit_in;
   assign wr_div  = i_wr && (i_addr == `SPR_OFF_DIV_LO || i_addr == `SPR_OFF_DIV_HI);
   assign rd_data = i_rd && (i_addr == `SPR_OFF_RX_DATA);
   assign wr_rx   = i_wr && (i_addr == `SPR_OFF_RX_CTRL);
   assign cont_nxt = wr_rx ? i_wdata[`SPR_RC_CONT] : cont_r;
   assign port_en_nxt = wr_rx ? i_wdata[`SPR_RC_PORT_EN] : port_en_r;
   // port disable resets the whole receive path
   assign port_rst = !i_rst_b || !port_en_r;
   assign char_bits = ninth_en_r ? 4'h9 : 4'h8;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   spr_sync2 u_sync_data (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .i_async (i_data_pin),
      .o_sync  (data_s)
   );
   spr_sync2 u_sync_clk (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .i_async (i_clock_pin),
      .o_sync  (clk_s)
   );
   // ----------------------------------------
   // baud generator
   // ----------------------------------------
   spr_baud_generator #(
      .DIV_W (16)
   ) u_baud (
      .i_clock   (i_clock),
      .i_rst_b   (i_rst_b),
      .i_clear   (wr_div),
      .i_divisor ({div_hi_r, div_lo_r}),
      .i_wide    (wide_r),
      .i_sync    (sync_r),
      .i_hspeed  (hspeed_r),
      .o_tick    (tick)
   );
   // ----------------------------------------
   // pin drivers
   // ----------------------------------------
   // receive path never drives the data pin
   assign o_data_pin    = 1'b0;
   assign o_data_pin_oe = 1'b0;
   // master drives its clock, slave only listens
   assign o_clock_pin    = sck_r;
   assign o_clock_pin_oe = port_en_r && sync_r && master_r;
   // ----------------------------------------
   // clock generation and edge detection
   // ----------------------------------------
   // overrun stalls reception until it is cleared
   assign active = port_en_r && sync_r && (single_r || cont_r) && !overrun_r;
   // master sees its own falling edge, slave the synchronised pin
   assign trail  = master_r ? (sck_prev_r && !sck_r) : (sck_prev_r && !clk_s);
   assign done   = trail && active && (bits_r == char_bits - 4'h1);
   // slave edge arrives two cycles late through its synchroniser, as data_s does; delayed data samples the pin a cycle before the edge
   assign bit_in = master_r ? data_s : data_d_r;
   always @(posedge i_clock) begin
      if (port_rst) begin
         sck_r      <= 1'b0;
         sck_prev_r <= 1'b0;
         data_d_r   <= 1'b0;
      end else begin
         sck_prev_r <= master_r ? sck_r : clk_s;
         data_d_r   <= data_s;
         if (!active || !master_r) begin
            sck_r <= 1'b0;
         end else if (tick) begin
            sck_r <= ~sck_r;
         end
      end
   end
   // ----------------------------------------
   // receive shift register
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (port_rst || !active) begin
         shift_r <= 9'h000;
         bits_r  <= 4'h0;
      end else if (trail) begin
         // lsb first: shift right, new bit at top of the character
         if (ninth_en_r) begin
            shift_r <= {bit_in, shift_r[8:1]};
         end else begin
            shift_r <= {1'b0, bit_in, shift_r[7:1]};
         end
         bits_r <= done ? 4'h0 : bits_r + 4'h1;
      end
   end
   // ----------------------------------------
   // control registers, FIFO and overrun
   // ----------------------------------------
   wire [8:0] new_char = ninth_en_r ? {bit_in, shift_r[8:1]} : {1'b0, bit_in, shift_r[7:1]};
   wire       pop      = rd_data && (count_r != 2'h0);
   wire       push     = done && (count_r != 2'h2 || pop);
   wire       ovr_set  = done && count_r == 2'h2 && !pop;
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         div_lo_r   <= `SPR_RST_BYTE;
         div_hi_r   <= `SPR_RST_BYTE;
         wide_r     <= 1'b0;
         hspeed_r   <= 1'b0;
         sync_r     <= 1'b0;
         master_r   <= 1'b0;
         port_en_r  <= 1'b0;
         ninth_en_r <= 1'b0;
      end else if (i_wr) begin
         case (i_addr)
            `SPR_OFF_DIV_LO: div_lo_r <= i_wdata;
            `SPR_OFF_DIV_HI: div_hi_r <= i_wdata;
            `SPR_OFF_BAUD_CTRL: wide_r <= i_wdata[`SPR_BC_WIDE];
            `SPR_OFF_TX_CTRL: begin
               hspeed_r <= i_wdata[`SPR_TC_HSPEED];
               sync_r   <= i_wdata[`SPR_TC_SYNC];
               master_r <= i_wdata[`SPR_TC_MASTER];
            end
            `SPR_OFF_RX_CTRL: begin
               port_en_r  <= i_wdata[`SPR_RC_PORT_EN];
               ninth_en_r <= i_wdata[`SPR_RC_NINTH_EN];
            end
            default: ;
         endcase
      end
   end
   // receive state; port disable resets it, but enabling the port with a start bit starts at once
   always @(posedge i_clock) begin
      if (!i_rst_b || !port_en_nxt) begin
         single_r     <= 1'b0;
         cont_r       <= 1'b0;
         overrun_r    <= 1'b0;
         ovr_single_r <= 1'b0;
         count_r      <= 2'h0;
         fifo_r[0]    <= 9'h000;
         fifo_r[1]    <= 9'h000;
      end else begin
         cont_r <= cont_nxt;
         if (wr_rx) begin
            single_r <= i_wdata[`SPR_RC_SINGLE];
         end
         // completion clears single, winning over a same-cycle write
         if (done && (single_r || cont_r)) begin
            single_r <= 1'b0;
         end
         // fifo: slot 0 is oldest
         if (pop && push) begin
            fifo_r[0] <= (count_r == 2'h2) ? fifo_r[1] : new_char;
            fifo_r[1] <= new_char;
         end else if (pop) begin
            fifo_r[0] <= fifo_r[1];
            count_r   <= count_r - 2'h1;
         end else if (push) begin
            fifo_r[count_r[0]] <= new_char;
            count_r <= count_r + 2'h1;
         end
         // overrun: set wins; clear by read if single-only, else by continuous clear
         if (ovr_set) begin
            overrun_r    <= 1'b1;
            ovr_single_r <= !cont_r;
         end else if (overrun_r && ovr_single_r && rd_data) begin
            overrun_r <= 1'b0;
         end else if (overrun_r && !ovr_single_r && !cont_nxt) begin
            overrun_r <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // read data, one cycle after the strobe
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (!i_rst_b) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `SPR_OFF_DIV_LO:    o_rdata <= div_lo_r;
            `SPR_OFF_DIV_HI:    o_rdata <= div_hi_r;
            `SPR_OFF_BAUD_CTRL: o_rdata <= {1'b0, !active, 2'h0, wide_r, 3'h0};
            `SPR_OFF_TX_CTRL:   o_rdata <= {master_r, 2'h0, sync_r, 1'b0, hspeed_r, 2'h0};
            `SPR_OFF_RX_CTRL:   o_rdata <= {port_en_r, ninth_en_r, single_r, cont_r,
                                            count_r != 2'h0, 1'b0, overrun_r, fifo_r[0][8]};
            `SPR_OFF_RX_DATA:   o_rdata <= fifo_r[0][7:0];
            default:            o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/spr_serial_port_checker.sv ----
// Purpose: port-level assertions for the serial port receive path
// Assumes: idle-low serial clock, rising edge leading
// Notes:   mirror flags track the enables that the pin drivers follow
`include "spr_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module spr_serial_port_checker (
   input wire logic                   i_clock,
   input wire logic                   i_rst_b,
   input wire logic [`SPR_ADDR_W-1:0] i_addr,
   input wire logic [7:0]             i_wdata,
   input wire logic                   i_wr,
   input wire logic                   i_rd,
   input wire logic [7:0]             o_rdata,
   input wire logic                   o_data_pin,
   input wire logic                   o_data_pin_oe,
   input wire logic                   o_clock_pin,
   input wire logic                   o_clock_pin_oe
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   logic en_r;
   logic sync_r;
   logic mst_r;
   logic quiet_r;
   // -----------------------------
   // write mirror
   // -----------------------------
   // mirrors land on the write edge, as the register file does
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         en_r    <= 1'b0;
         sync_r  <= 1'b0;
         mst_r   <= 1'b0;
         quiet_r <= 1'b1;
      end else if (i_wr && i_addr == `SPR_OFF_RX_CTRL) begin
         en_r    <= i_wdata[`SPR_RC_PORT_EN];
         quiet_r <= i_wdata[`SPR_RC_SINGLE:`SPR_RC_CONT] == 2'b00;
      end else if (i_wr && i_addr == `SPR_OFF_TX_CTRL) begin
         sync_r <= i_wdata[`SPR_TC_SYNC];
         mst_r  <= i_wdata[`SPR_TC_MASTER];
      end
   end
   sequence rx_stop_wr;
      i_wr && i_addr == `SPR_OFF_RX_CTRL && i_wdata[`SPR_RC_SINGLE:`SPR_RC_CONT] == 2'b00;
   endsequence
   sequence div_wr;
      i_wr && i_addr <= `SPR_OFF_DIV_HI;
   endsequence
   data_drv_off_a: assert property (!o_data_pin_oe && !o_data_pin)
      else $error("data pin driven");
   clk_drv_a: assert property (o_clock_pin_oe == (en_r && sync_r && mst_r))
      else $error("clock pin enable wrong");
   rise_en_a: assert property ($rose(o_clock_pin) |-> o_clock_pin_oe)
      else $error("clock rose while not master");
   low_hold_a: assert property ($fell(o_clock_pin) |-> !o_clock_pin [*4])
      else $error("clock low phase short");
   high_hold_a: assert property ($rose(o_clock_pin) |-> (o_clock_pin || quiet_r) [*4])
      else $error("clock high phase short");
   cont_stop_a: assert property (rx_stop_wr |-> ##2 !o_clock_pin [*8])
      else $error("clock ran after receive stop");
   div_clear_a: assert property (div_wr |-> ##2 $stable(o_clock_pin) [*3])
      else $error("clock moved right after divisor write");
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside read slot");
endmodule
bind spr_serial_port spr_serial_port_checker spr_serial_port_checker_inst (.i_clock(i_clock), .i_rst_b(i_rst_b),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_data_pin(o_data_pin),
   .o_data_pin_oe(o_data_pin_oe), .o_clock_pin(o_clock_pin), .o_clock_pin_oe(o_clock_pin_oe));
`default_nettype wire

// ---- testbench/spr_remote_slave.sv ----
// Purpose: remote synchronous device shifting characters to the receiver
// Assumes: master clock idles low, so the rising edge leads
// Notes:   each character is the previous plus one, from i_base
`timescale 1ns/1ps
`default_nettype none
module spr_remote_slave (
   input  wire logic       i_sck,
   input  wire logic       i_restart,
   input  wire logic [8:0] i_base,
   input  wire logic       i_nine,
   output var  logic       o_data
);
   logic [3:0] bit_r;
   logic [8:0] word_r;
   initial o_data = 1'b1;
   // -----------------------------
   // shifter
   // -----------------------------
   // restart realigns framing after a dropped character
   always @(posedge i_sck or negedge i_sck or posedge i_restart) begin
      if (i_restart) begin
         bit_r  <= 4'h0;
         word_r <= i_base;
      end else if (i_sck) begin
         o_data <= word_r[bit_r];
         bit_r  <= (bit_r == (i_nine ? 4'h8 : 4'h7)) ? 4'h0 : bit_r + 4'h1;
         if (bit_r == (i_nine ? 4'h8 : 4'h7))
            word_r <= word_r + 9'h001;
      end else if (bit_r == 4'h0) begin
         o_data <= ~o_data; // line not held past the last bit, so show junk
      end
   end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the serial port receive path
// Assumes: sync receive against the remote shifter model, as master or as slave on a driven clock pin
// Notes:   divisor zero during traffic gives a four clock half period
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       i_clock = 1'b0;
   logic       i_rst_b = 1'b0;
   logic       i_wr    = 1'b0;
   logic       i_rd    = 1'b0;
   logic       restart = 1'b0;
   logic       nine    = 1'b0;
   logic       ext_sck = 1'b0;
   logic [2:0] i_addr  = 3'h0;
   logic [7:0] i_wdata = 8'h00;
   logic [7:0] v;
   logic [8:0] base    = 9'h000;
   wire  [7:0] o_rdata;
   wire        o_data_pin, o_data_pin_oe, o_clock_pin, o_clock_pin_oe, sdata;
   int         miscompares = 0;
   int         n_tests     = 0;
   int         rises       = 0;
   spr_serial_port spr_serial_port_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_data_pin(sdata), .o_data_pin(o_data_pin),
      .o_data_pin_oe(o_data_pin_oe), .i_clock_pin(ext_sck), .o_clock_pin(o_clock_pin), .o_clock_pin_oe(o_clock_pin_oe));
   spr_remote_slave spr_remote_slave_inst (.i_sck(o_clock_pin | ext_sck), .i_restart(restart), .i_base(base),
      .i_nine(nine), .o_data(sdata));
   // -----------------------------
   // clock, edge count, watchdog
   // -----------------------------
   initial forever #10 i_clock = ~i_clock;
   always @(posedge o_clock_pin) rises++;
   // whole run needs a few thousand cycles; a hang stops here
   initial begin
      repeat (20000) @(posedge i_clock);
      miscompares++;
      stop_test;
   end
   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr    <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task rd(input logic [2:0] a);
      @(posedge i_clock);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd   <= 1'b0;
      #1 v = o_rdata;
   endtask
   task poll(input int b);
      for (int k = 0; k < 300; k++) begin
         rd(3'h4);
         if (v[b] === 1'b1)
            break;
      end
   endtask
   // idle gap keeps a restart clear of the stop window after the last transfer
   task prep(input logic [8:0] b, input logic nb);
      repeat (8) @(posedge i_clock);
      base    <= b;
      nine    <= nb;
      restart <= 1'b1;
      @(posedge i_clock);
      restart <= 1'b0;
      rises = 0;
   endtask
   task t_one(input logic [8:0] b, input logic nb, input logic [7:0] ctrl, input int nclk);
      prep(b, nb);
      wr(3'h4, ctrl);
      poll(3);
      chk("pending", v[3], 1'b1);
      chk("single", v[5], 1'b0);
      chk("ninth", v[0], b[8] & nb);
      repeat (30) @(posedge i_clock);
      chk("clocks", rises, nclk);
      rd(3'h5);
      chk("data", v, b[7:0]);
      rd(3'h4);
      chk("drained", v[3], 1'b0);
      wr(3'h4, 8'h80);
   endtask
   task t_ovr;
      prep(9'h030, 1'b0);
      wr(3'h4, 8'hb0);
      poll(1);
      chk("single", v[5], 1'b0);
      chk("pending", v[3], 1'b1);
      rd(3'h5);
      chk("first", v, 8'h30);
      rd(3'h5);
      chk("second", v, 8'h31);
      rd(3'h4);
      chk("ovr kept", v[3:1], 3'h1);
      wr(3'h4, 8'h80);
      rd(3'h4);
      chk("ovr clear", v[1], 1'b0);
   endtask
   // three single receptions with no read: overrun clears on a data read
   task t_ovr1;
      prep(9'h040, 1'b0);
      repeat (3) begin
         wr(3'h4, 8'ha0);
         repeat (90) @(posedge i_clock);
      end
      rd(3'h4);
      chk("ovr single", v[1], 1'b1);
      rd(3'h5);
      chk("ovr data", v, 8'h40);
      rd(3'h4);
      chk("ovr read clr", v[1], 1'b0);
      wr(3'h4, 8'h00);
      rd(3'h4);
      chk("port off", v[3], 1'b0);
   endtask
   // external clock on the clock pin, six system clocks per phase
   task t_slave;
      wr(3'h3, 8'h10);
      prep(9'h0b7, 1'b0);
      wr(3'h4, 8'h90);
      chk("clk oe", o_clock_pin_oe, 1'b0);
      repeat (8) begin
         repeat (6) @(posedge i_clock);
         ext_sck <= 1'b1;
         repeat (6) @(posedge i_clock);
         ext_sck <= 1'b0;
      end
      repeat (10) @(posedge i_clock);
      rd(3'h4);
      chk("slave pending", v[3], 1'b1);
      rd(3'h5);
      chk("slave data", v, 8'hb7);
      wr(3'h4, 8'h00);
   endtask
   // stop lands inside a low phase so the drop is visible as no more edges
   task t_abort;
      prep(9'h055, 1'b0);
      wr(3'h4, 8'h90);
      wait (rises == 3);
      @(negedge o_clock_pin);
      wr(3'h4, 8'h80);
      repeat (100) @(posedge i_clock);
      chk("abort clocks", rises, 3);
      rd(3'h4);
      chk("partial", v[3], 1'b0);
   endtask
   task t_rate(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] bc, input logic [7:0] tc,
      input int exp);
      int n;
      n = 0;
      rd(3'h2);
      chk("idle", v[6], 1'b1);
      wr(3'h0, lo);
      wr(3'h1, hi);
      wr(3'h2, bc);
      wr(3'h3, tc);
      wr(3'h4, 8'h90);
      // rewrite the divisor while the clock runs; measure only after the clear
      wr(3'h0, lo);
      wr(3'h1, hi);
      @(posedge o_clock_pin);
      @(posedge o_clock_pin);
      while (o_clock_pin === 1'b1) begin
         @(posedge i_clock);
         #1 n = n + 1;
      end
      wr(3'h4, 8'h80);
      chk("half period", n, exp);
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rd(3'h7);
      chk("unmapped", v, 8'h00);
      wr(3'h3, 8'h90);
      t_one(9'h0a5, 1'b0, 8'ha0, 8);
      t_one(9'h1c3, 1'b1, 8'he0, 9);
      t_ovr;
      t_ovr1;
      t_abort;
      t_slave;
      t_rate(8'h02, 8'h00, 8'h00, 8'h90, 12);
      t_rate(8'h01, 8'h05, 8'h00, 8'h94, 8);
      t_rate(8'h00, 8'h01, 8'h08, 8'h90, 1028);
      stop_test;
   end
endmodule
`default_nettype wire
